// File: hdl/hss_filter.sv
/*
 * persistence filter: output rises once the input has been high for
 * LIMIT consecutive cycles, falls at once when the input drops.
 * assumes a synchronous, already clean condition input.
 */
`timescale 1ns/1ps
module hss_filter
    import hss_pkg::*;
#(
    parameter int LIMIT = 640
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // condition
    input  wire logic cond,
    output logic      persisted
);
    localparam int CW = $clog2(LIMIT + 1);

    logic [CW-1:0] count_reg;

    initial begin
        if (LIMIT < 1) begin
            $error("hss_filter LIMIT must be at least one");
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b || !cond) begin
            count_reg <= '0;
        end else if (count_reg != CW'(LIMIT)) begin
            count_reg <= count_reg + CW'(1);
        end
    end

    assign persisted = cond && (count_reg == CW'(LIMIT));
endmodule

// File: hdl/hss_switch_control.sv
/*
 * high-side switch control: four channels, source selection, supply fault
 * shutdown and recovery, filtered over-current shutdown and open-load flags,
 * all behind an avalon-mm slave with waitrequest.
 * assumes sbc mode, comparator and generator inputs synchronous to clock.
 */
// The register offsets and register access over Avalon-MM were left to the implementer.
// Functional notes
// - output source: direct, timer or pwm
// - stop/sleep keep config, ignore writes; the code still accepts the flag-clear writes to the supply and status words
// - restart or fail-safe forces outputs off
// - over-voltage turns channels off unless disabled
// - channels return after over-voltage clears, if recovery
// - under-voltage turns channels off unless disabled
// - channels return after under-voltage clears, if recovery
// - auto return only with recovery bit one
// - no recovery: stay off, control cleared
// - supply faults only set supply flags
// - filtered over-current switches channel off
// - over-current sets flag, config to 000
// - over-current flags sticky until software clears
// - open load checked only while on
// - per-channel open-load flag, channel stays on
// - open-load flags sticky, clear once condition gone
// - over-current filter 16 us
// - open-load filter 64 us
`timescale 1ns/1ps
module hss_switch_control
    import hss_pkg::*;
#(
    parameter int CHANNELS = NUM_CH,
    parameter int OC_CYC   = OC_FILTER_CYC,
    parameter int OL_CYC   = OL_FILTER_CYC
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_b,
    // avalon-mm slave
    input  wire logic [3:0]   avsAddress,
    input  wire logic         avsRead,
    input  wire logic         avsWrite,
    input  wire logic [31:0]  avsWriteData,
    input  wire logic [3:0]   avsByteEnable,
    output logic [31:0]       avsReadData,
    output logic              avsWaitRequest,
    // chip mode
    input  wire hss_mode_type sbcMode,
    // supply comparators
    input  wire logic         supplyOverVolt,
    input  wire logic         supplyUnderVolt,
    // generators
    input  wire logic         timer1Out,
    input  wire logic         timer2Out,
    input  wire logic         pwm1Out,
    input  wire logic         pwm2Out,
    // per-channel current comparators
    input  wire logic [3:0]   overCurrent,
    input  wire logic [3:0]   underOpenLoad,
    // switch drives
    output logic [3:0]        highSideOutput
);
    initial begin
        if (CHANNELS != NUM_CH || OC_CYC < 1 || OL_CYC < 1) begin
            $error("hss_switch_control: unsupported parameters");
        end
    end

    // channel configuration fields, three bits each
    logic [CFG_W-1:0] chCfg_reg [NUM_CH];
    logic [2:0]       supplyCfg_reg;
    logic             ovFlag_reg;
    logic             uvFlag_reg;
    logic [3:0]       ocFlag_reg;
    logic [3:0]       olFlag_reg;
    logic [3:0]       drive_reg;
    logic [31:0]      readData_reg;
    logic             ack_reg;
    logic [3:0]       ocTrip;
    logic [3:0]       olTrip;
    logic [3:0]       chOn;
    logic             ovShut;
    logic             uvShut;
    logic             supplyShut;
    logic             cfgWritable;
    logic             forcedOff;
    logic             wrStrobe;
    logic             rdStrobe;

    function automatic logic srcLevel(input logic [CFG_W-1:0] cfg,
                                      input logic t1, input logic t2,
                                      input logic p1, input logic p2);
        case (cfg)
            CFG_ON:     srcLevel = 1'b1;
            CFG_TIMER1: srcLevel = t1;
            CFG_TIMER2: srcLevel = t2;
            CFG_PWM1:   srcLevel = p1;
            CFG_PWM2:   srcLevel = p2;
            default:    srcLevel = 1'b0;
        endcase
    endfunction

    // one wait state: answer on the cycle after the request appears
    assign wrStrobe       = avsWrite && ack_reg;
    assign rdStrobe       = avsRead && ack_reg;
    assign avsWaitRequest = (avsRead || avsWrite) && !ack_reg;
    assign avsReadData    = readData_reg;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avsRead || avsWrite) && !ack_reg;
        end
    end

    assign cfgWritable = (sbcMode == MODE_NORMAL);
    assign forcedOff   = (sbcMode == MODE_RESTART) ||
                         (sbcMode == MODE_FAILSAFE);

    assign ovShut     = supplyOverVolt && !supplyCfg_reg[BIT_OV_DIS];
    assign uvShut     = supplyUnderVolt && !supplyCfg_reg[BIT_UV_DIS];
    assign supplyShut = ovShut || uvShut;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gChan
            // filters see the raw condition only while the channel drives
            hss_filter #(.LIMIT(OC_CYC)) uOcFilt (
                .clock     (clock),
                .rst_b     (rst_b),
                .cond      (overCurrent[g] && drive_reg[g]),
                .persisted (ocTrip[g])
            );
            hss_filter #(.LIMIT(OL_CYC)) uOlFilt (
                .clock     (clock),
                .rst_b     (rst_b),
                .cond      (underOpenLoad[g] && drive_reg[g]),
                .persisted (olTrip[g])
            );
            assign chOn[g] = srcLevel(chCfg_reg[g], timer1Out, timer2Out,
                                      pwm1Out, pwm2Out);
        end
    endgenerate

    // channel configuration, register a holds ch1/ch2, b holds ch3/ch4
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_CH; i++) begin
                chCfg_reg[i] <= CFG_OFF;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wrStrobe && cfgWritable && avsByteEnable[0] &&
                    avsAddress == ((i < 2) ? ADDR_CTRL_A : ADDR_CTRL_B)) begin
                    chCfg_reg[i] <= avsWriteData[(i % 2) * 4 +: CFG_W];
                end
                // shutdowns override a same-cycle write
                if (ocTrip[i]) begin
                    chCfg_reg[i] <= CFG_OFF;
                end else if (supplyShut && !supplyCfg_reg[BIT_REC_EN]) begin
                    chCfg_reg[i] <= CFG_OFF;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            supplyCfg_reg <= CTRL_RESET[2:0];
        end else if (wrStrobe && cfgWritable && avsByteEnable[0] &&
                     avsAddress == ADDR_SUPPLY) begin
            supplyCfg_reg <= avsWriteData[2:0];
        end
    end

    // output drive: recovery is implicit since config is kept
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            drive_reg <= 4'h0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                drive_reg[i] <= chOn[i] && !forcedOff && !supplyShut &&
                                !ocTrip[i];
            end
        end
    end

    assign highSideOutput = drive_reg;

    // sticky flags: hardware set wins over a same-cycle clear
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ovFlag_reg <= 1'b0;
            uvFlag_reg <= 1'b0;
        end else begin
            if (supplyOverVolt) begin
                ovFlag_reg <= 1'b1;
            end else if (wrStrobe && avsAddress == ADDR_SUPPLY &&
                         avsByteEnable[1] && avsWriteData[BIT_OV_FLAG]) begin
                ovFlag_reg <= 1'b0;
            end
            if (supplyUnderVolt) begin
                uvFlag_reg <= 1'b1;
            end else if (wrStrobe && avsAddress == ADDR_SUPPLY &&
                         avsByteEnable[1] && avsWriteData[BIT_UV_FLAG]) begin
                uvFlag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ocFlag_reg <= 4'h0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (ocTrip[i]) begin
                    ocFlag_reg[i] <= 1'b1;
                end else if (wrStrobe && avsAddress == ADDR_OC_STAT &&
                             avsByteEnable[0] && avsWriteData[i]) begin
                    ocFlag_reg[i] <= 1'b0;
                end
            end
        end
    end

    // open-load flags share the over-current status word, bits 11:8
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            olFlag_reg <= 4'h0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (olTrip[i]) begin
                    olFlag_reg[i] <= 1'b1;
                end else if (wrStrobe && avsAddress == ADDR_OC_STAT &&
                             avsByteEnable[1] && avsWriteData[8 + i]) begin
                    olFlag_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            readData_reg <= 32'h0000_0000;
        end else if (rdStrobe || (avsRead && !ack_reg)) begin
            case (avsAddress)
                ADDR_CTRL_A:
                    readData_reg <= {25'h0, chCfg_reg[1], 1'b0, chCfg_reg[0]};
                ADDR_CTRL_B:
                    readData_reg <= {25'h0, chCfg_reg[3], 1'b0, chCfg_reg[2]};
                ADDR_SUPPLY:
                    readData_reg <= {22'h0, uvFlag_reg, ovFlag_reg,
                                     5'h00, supplyCfg_reg};
                ADDR_OC_STAT:
                    readData_reg <= {20'h0, olFlag_reg, 4'h0, ocFlag_reg};
                default:
                    readData_reg <= 32'h0000_0000;
            endcase
        end
    end

    // checks
    property p_oc_off;
        @(posedge clock) disable iff (!rst_b)
        ocTrip[1] |=> !highSideOutput[1] && chCfg_reg[1] == CFG_OFF;
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("oc no shutdown");

    property p_oc_flag;
        @(posedge clock) disable iff (!rst_b)
        ocTrip[1] |=> ocFlag_reg[1];
    endproperty
    a_oc_flag: assert property (p_oc_flag) else $error("oc flag");

    property p_ol_stays;
        @(posedge clock) disable iff (!rst_b)
        olTrip[2] && chOn[2] && !forcedOff && !supplyShut && !ocTrip[2]
        |=> highSideOutput[2] && olFlag_reg[2];
    endproperty
    a_ol_stays: assert property (p_ol_stays) else $error("ol");

    property p_forced;
        @(posedge clock) disable iff (!rst_b)
        forcedOff |=> highSideOutput == 4'h0;
    endproperty
    a_forced: assert property (p_forced) else $error("forced off");

    property p_ov;
        @(posedge clock) disable iff (!rst_b)
        supplyOverVolt && !supplyCfg_reg[BIT_OV_DIS]
        |=> highSideOutput == 4'h0 && ovFlag_reg;
    endproperty
    a_ov: assert property (p_ov) else $error("ov shutdown");

    property p_uv;
        @(posedge clock) disable iff (!rst_b)
        supplyUnderVolt && !supplyCfg_reg[BIT_UV_DIS]
        |=> highSideOutput == 4'h0 && uvFlag_reg;
    endproperty
    a_uv: assert property (p_uv) else $error("uv shutdown");

    property p_norec;
        @(posedge clock) disable iff (!rst_b)
        supplyShut && !supplyCfg_reg[BIT_REC_EN] |=> chCfg_reg[3] == CFG_OFF;
    endproperty
    a_norec: assert property (p_norec) else $error("no recovery");

    property p_frozen;
        @(posedge clock) disable iff (!rst_b)
        !cfgWritable && !ocTrip[0] && !supplyShut |=> $stable(chCfg_reg[0]);
    endproperty
    a_frozen: assert property (p_frozen) else $error("cfg changed");

    property p_wait;
        @(posedge clock) disable iff (!rst_b)
        (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bus stall");

    property p_sup_flags;
        @(posedge clock) disable iff (!rst_b)
        supplyShut && ocTrip == 4'h0 && olTrip == 4'h0
        |=> (ocFlag_reg & ~$past(ocFlag_reg)) == 4'h0 &&
            (olFlag_reg & ~$past(olFlag_reg)) == 4'h0;
    endproperty
    a_sup_flags: assert property (p_sup_flags) else $error("flag set");

    property p_oc_sticky;
        @(posedge clock) disable iff (!rst_b)
        ocFlag_reg[1] && !(wrStrobe && avsAddress == ADDR_OC_STAT &&
                           avsByteEnable[0] && avsWriteData[1])
        |=> ocFlag_reg[1];
    endproperty
    a_oc_sticky: assert property (p_oc_sticky) else $error("oc lost");

    property p_ol_sticky;
        @(posedge clock) disable iff (!rst_b)
        olFlag_reg[2] && !(wrStrobe && avsAddress == ADDR_OC_STAT &&
                           avsByteEnable[1] && avsWriteData[10])
        |=> olFlag_reg[2];
    endproperty
    a_ol_sticky: assert property (p_ol_sticky) else $error("ol lost");

    c_oc: cover property (@(posedge clock) disable iff (!rst_b) ocTrip[1]);
    c_ol: cover property (@(posedge clock) disable iff (!rst_b) olTrip[2]);
    c_rec: cover property (@(posedge clock) disable iff (!rst_b)
        supplyShut && supplyCfg_reg[BIT_REC_EN] ##1 !supplyShut);
    c_refused: cover property (@(posedge clock) disable iff (!rst_b)
        wrStrobe && !cfgWritable);
    c_forced: cover property (@(posedge clock) disable iff (!rst_b)
        forcedOff && chOn != 4'h0);
endmodule

// File: include/hss_pkg.sv
/*
 * shared constants for the high-side switch control block: register map,
 * configuration codes, sbc mode encoding and filter times.
 * assumes a 40 MHz system clock and a 32-bit avalon-mm register port.
 */
package hss_pkg;
    localparam int CLOCK_HZ          = 40000000;
    localparam int NUM_CH            = 4;
    localparam int CFG_W             = 3;

    // filter times in microseconds, cycle counts derived from the clock
    localparam int OC_FILTER_US      = 16;
    localparam int OL_FILTER_US      = 64;
    localparam int OC_FILTER_CYC     = OC_FILTER_US * (CLOCK_HZ / 1000000);
    localparam int OL_FILTER_CYC     = OL_FILTER_US * (CLOCK_HZ / 1000000);

    // word offsets (byte addresses)
    localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B   = 4'h4;
    localparam logic [3:0] ADDR_SUPPLY   = 4'h8;
    localparam logic [3:0] ADDR_OC_STAT  = 4'hC;
    localparam logic [3:0] ADDR_OL_STAT  = 4'h0;
    localparam logic [1:0] ADDR_HI_OL    = 2'h1;

    // supply config / status field positions
    localparam int BIT_OV_DIS        = 0;
    localparam int BIT_UV_DIS        = 1;
    localparam int BIT_REC_EN        = 2;
    localparam int BIT_OV_FLAG       = 8;
    localparam int BIT_UV_FLAG       = 9;

    // channel configuration codes
    localparam logic [2:0] CFG_OFF    = 3'h0;
    localparam logic [2:0] CFG_ON     = 3'h1;
    localparam logic [2:0] CFG_TIMER1 = 3'h2;
    localparam logic [2:0] CFG_TIMER2 = 3'h3;
    localparam logic [2:0] CFG_PWM1   = 3'h4;
    localparam logic [2:0] CFG_PWM2   = 3'h5;

    localparam logic [11:0] CTRL_RESET = 12'h000;

    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } hss_mode_type;
endpackage

// File: testbench/hss_load_model.sv
/*
 * load model for the four high-side outputs: normal, shorted or open load
 * per channel, seen through registered current comparators.
 * assumes the bench picks the load kind and the switch drives it.
 */
`timescale 1ns/1ps
module hss_load_model
    import hss_pkg::*;
(
    // clock
    input  wire logic       clock,
    // load selection
    input  wire logic [3:0] shortLoad,
    input  wire logic [3:0] openLoad,
    // switch side
    input  wire logic [3:0] highSideOutput,
    output logic      [3:0] overCurrent,
    output logic      [3:0] underOpenLoad
);
    // an off switch carries no current, so it reads below the open-load
    // level; the block has to ignore that while the channel is off
    always_ff @(posedge clock) begin
        overCurrent   <= highSideOutput & shortLoad;
        underOpenLoad <= ~highSideOutput | openLoad;
    end
endmodule

// File: testbench/hss_switch_control_tb.sv
/*
 * self-checking bench for the high-side switch control block.
 * assumes small filter lengths; bus tasks wait for waitrequest low.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
module hss_switch_control_tb
    import hss_pkg::*;
;
    logic         clock;
    logic         rst_b;
    logic [3:0]   avsAddress;
    logic         avsRead;
    logic         avsWrite;
    logic [31:0]  avsWriteData;
    logic [3:0]   avsByteEnable;
    logic [31:0]  avsReadData;
    logic         avsWaitRequest;
    hss_mode_type sbcMode;
    logic         supplyOverVolt;
    logic         supplyUnderVolt;
    logic [3:0]   gen;
    logic [3:0]   overCurrent;
    logic [3:0]   underOpenLoad;
    logic [3:0]   highSideOutput;
    logic [3:0]   shortLoad;
    logic [3:0]   openLoad;
    logic [31:0]  d;
    int           num_errors;
    int           cmp_count;

    hss_switch_control #(.OC_CYC(4), .OL_CYC(8)) hss_switch_control_inst (
        .clock(clock), .rst_b(rst_b), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .sbcMode(sbcMode),
        .supplyOverVolt(supplyOverVolt), .supplyUnderVolt(supplyUnderVolt),
        .timer1Out(gen[0]), .timer2Out(gen[1]), .pwm1Out(gen[2]),
        .pwm2Out(gen[3]), .overCurrent(overCurrent),
        .underOpenLoad(underOpenLoad), .highSideOutput(highSideOutput));

    hss_load_model hss_load_model_inst (
        .clock(clock), .shortLoad(shortLoad), .openLoad(openLoad),
        .highSideOutput(highSideOutput), .overCurrent(overCurrent),
        .underOpenLoad(underOpenLoad));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // request held until waitrequest is seen low, then one idle edge
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] wd, input logic [3:0] be);
        avsAddress    <= a;
        avsWriteData  <= wd;
        avsByteEnable <= be;
        avsWrite      <= wr;
        avsRead       <= ~wr;
        // no local limit: a slave that never answers trips the watchdog
        do begin
            @(posedge clock);
        end while (avsWaitRequest !== 1'b0);
        d = avsReadData;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF);
        `CHK(d, e)
    endtask

    task automatic outChk(input logic [3:0] e);
        cyc(3);
        `CHK(highSideOutput, e)
    endtask

    task automatic t_reset;
        `CHK(highSideOutput, 4'h0)
        rdChk(ADDR_CTRL_A, 32'h0);
        rdChk(ADDR_SUPPLY, 32'h0);
        rdChk(ADDR_OC_STAT, 32'h0);
    endtask

    task automatic t_sources;
        bus(1'b1, ADDR_CTRL_A, 32'h21, 4'hF);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, ADDR_CTRL_B, k ? 32'h53 : 32'h43, 4'hF);
            for (int p = 0; p < 16; p++) begin
                gen <= p[3:0];
                outChk({k ? p[3] : p[2], p[1], p[0], 1'b1});
            end
        end
        gen <= 4'h0;
    endtask

    task automatic t_modes;
        hss_mode_type ms [4];
        ms = '{MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE};
        bus(1'b1, ADDR_CTRL_A, 32'h11, 4'hF);
        bus(1'b1, ADDR_CTRL_B, 32'h11, 4'hF);
        for (int i = 0; i < 2; i++) begin
            sbcMode <= ms[i];
            bus(1'b1, ADDR_CTRL_A, 32'h0, 4'hF);
            outChk(4'hF);
            rdChk(ADDR_CTRL_A, 32'h11);
        end
        for (int i = 2; i < 4; i++) begin
            sbcMode <= ms[i];
            outChk(4'h0);
        end
        sbcMode <= MODE_NORMAL;
        cyc(1);
    endtask

    task automatic t_supply;
        bus(1'b1, ADDR_SUPPLY, 32'h4, 4'h1);
        bus(1'b1, ADDR_CTRL_A, 32'h11, 4'hF);
        bus(1'b1, ADDR_CTRL_B, 32'h11, 4'hF);
        for (int f = 0; f < 2; f++) begin
            {supplyUnderVolt, supplyOverVolt} <= f ? 2'b10 : 2'b01;
            outChk(4'h0);
            bus(1'b0, ADDR_SUPPLY, 32'h0, 4'hF);
            `CHK(d[9:8], f ? 2'b10 : 2'b01)
            rdChk(ADDR_OC_STAT, 32'h0);
            {supplyUnderVolt, supplyOverVolt} <= 2'b00;
            outChk(4'hF);
            bus(1'b1, ADDR_SUPPLY, 32'h304, 4'h3);
        end
        bus(1'b1, ADDR_SUPPLY, 32'h7, 4'h1);
        {supplyUnderVolt, supplyOverVolt} <= 2'b11;
        outChk(4'hF);
        {supplyUnderVolt, supplyOverVolt} <= 2'b00;
        bus(1'b1, ADDR_SUPPLY, 32'h300, 4'h3);
        supplyUnderVolt <= 1'b1;
        outChk(4'h0);
        supplyUnderVolt <= 1'b0;
        outChk(4'h0);
        rdChk(ADDR_CTRL_A, 32'h0);
    endtask

    task automatic t_overcurrent;
        bus(1'b1, ADDR_CTRL_A, 32'h11, 4'hF);
        bus(1'b1, ADDR_CTRL_B, 32'h11, 4'hF);
        // a glitch shorter than the filter must not trip
        shortLoad <= 4'h2;
        cyc(2);
        shortLoad <= 4'h0;
        outChk(4'hF);
        shortLoad <= 4'h2;
        outChk(4'hF);
        cyc(6);
        `CHK(highSideOutput, 4'hD)
        rdChk(ADDR_CTRL_A, 32'h01);
        rdChk(ADDR_OC_STAT, 32'h2);
        shortLoad <= 4'h0;
        cyc(5);
        rdChk(ADDR_OC_STAT, 32'h2);
        bus(1'b1, ADDR_OC_STAT, 32'h2, 4'h1);
        rdChk(ADDR_OC_STAT, 32'h0);
        bus(1'b1, ADDR_CTRL_A, 32'h11, 4'hF);
        outChk(4'hF);
    endtask

    task automatic t_openload;
        bus(1'b1, ADDR_CTRL_B, 32'h10, 4'hF);
        openLoad <= 4'h4;
        cyc(16);
        rdChk(ADDR_OC_STAT, 32'h0);
        bus(1'b1, ADDR_CTRL_B, 32'h11, 4'hF);
        cyc(4);
        rdChk(ADDR_OC_STAT, 32'h0);
        cyc(12);
        rdChk(ADDR_OC_STAT, 32'h400);
        `CHK(highSideOutput, 4'hF)
        bus(1'b1, ADDR_OC_STAT, 32'h400, 4'h2);
        cyc(3);
        rdChk(ADDR_OC_STAT, 32'h400);
        openLoad <= 4'h0;
        cyc(3);
        bus(1'b1, ADDR_OC_STAT, 32'h400, 4'h2);
        rdChk(ADDR_OC_STAT, 32'h0);
    endtask

    task automatic end_sim;
        $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        num_errors = 0;
        cmp_count = 0;
        rst_b = 1'b0;
        {avsRead, avsWrite, avsAddress, avsWriteData} = '0;
        avsByteEnable = 4'h0;
        sbcMode = MODE_NORMAL;
        {supplyOverVolt, supplyUnderVolt} = 2'b00;
        gen = 4'h0;
        shortLoad = 4'h0;
        openLoad = 4'h0;
        cyc(20);
        rst_b <= 1'b1;
        cyc(1);
        t_reset;
        t_sources;
        t_modes;
        t_supply;
        t_overcurrent;
        t_openload;
        end_sim;
    end

    // the whole run needs well under two thousand cycles
    initial begin
        cyc(20000);
        num_errors++;
        end_sim;
    end
endmodule
